// >>> common/mcr_pkg.sv
// constants for the monitor configuration register block
// ****************************************************************************
// ****************************************************************************
package mcr_pkg;

   // ************************************************************************
   // register offsets
   // ************************************************************************
   localparam logic [7:0] INTR_CLEAR_ADDR   = 8'h46;
   localparam logic [7:0] VID_FAN_DIV_ADDR  = 8'h47;
   localparam logic [7:0] BUS_ADDRESS_ADDR  = 8'h48;
   localparam logic [7:0] VID_HIGH_ADDR     = 8'h49;
   localparam logic [7:0] TEMP_CONFIG_ADDR  = 8'h4b;

   // ************************************************************************
   // field positions
   // ************************************************************************
   localparam int INTR_CLEAR_BIT  = 7;
   localparam int FAN1_DIV_LSB    = 4;
   localparam int FAN2_DIV_LSB    = 6;
   localparam int TEMP_NINTH_BIT  = 7;

   // ************************************************************************
   // reset values
   // ************************************************************************
   localparam logic [7:0] INTR_CLEAR_RESET  = 8'h00;
   localparam logic [3:0] FAN_DIV_RESET     = 4'h0;
   localparam logic [5:0] BUS_ADDR_PATTERN  = 6'b001011;
   localparam logic [6:0] VID_HIGH_RESET    = 7'b1000000;
   localparam logic [1:0] TEMP_MODE_RESET   = 2'b01;
   localparam logic [4:0] TEMP_RSV_RESET    = 5'h00;

   // ************************************************************************
   // temperature interrupt mode codes
   // ************************************************************************
   localparam logic [1:0] MODE_ONE_TIME     = 2'b01;
   localparam logic [1:0] MODE_COMPARATOR   = 2'b10;

   // ************************************************************************
   // timing
   // ************************************************************************
   localparam int CLK_KHZ            = 125000;
   localparam int CLEAR_PULSE_MS     = 20;
   localparam int CLEAR_PULSE_CYCLES = CLEAR_PULSE_MS * CLK_KHZ;
   localparam int PULSE_CNT_W        = 22;
   localparam int FAN_CNT_W          = 8;
   localparam logic [FAN_CNT_W-1:0] FAN_CNT_MAX = 8'hff;

   // one-time mode tracking
   typedef enum logic {
      OT_WAIT_HIGH,
      OT_WAIT_LOW
   } mcr_otime_type;

endpackage

// >>> dv/mcr_host_model.sv
// register port master standing in for the serial engine
`timescale 1ns/1ps
module mcr_host_model (
   // clock
   input  wire logic       i_clk,
   // register port
   output logic      [7:0] o_reg_addr,
   output logic      [7:0] o_reg_wdata,
   output logic            o_reg_write,
   output logic            o_reg_read,
   input  wire logic [7:0] i_reg_rdata
);
   // idle from time zero
   initial begin
      o_reg_addr  = 8'h00;
      o_reg_wdata = 8'h00;
      o_reg_write = 1'h0;
      o_reg_read  = 1'h0;
   end
   // released lines flip so a stale address is never mistaken for a live one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_reg_addr  <= a;
      o_reg_wdata <= d;
      o_reg_write <= 1'h1;
      @(posedge i_clk);
      o_reg_write <= 1'h0;
      o_reg_addr  <= ~a;
      o_reg_wdata <= ~d;
   endtask
   // data is taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_reg_addr <= a;
      o_reg_read <= 1'h1;
      @(posedge i_clk);
      o_reg_read <= 1'h0;
      o_reg_addr <= ~a;
      @(negedge i_clk);
      d = i_reg_rdata;
   endtask
endmodule

// >>> dv/mcr_monitor_config_registers_sva.sv
// port assertions for the monitor configuration registers
`timescale 1ns/1ps
module mcr_monitor_config_registers_sva #(
   parameter int CLEAR_PULSE_CYCLES = 20
) (
   // clock and reset
   input wire logic       i_clk,
   input wire logic       i_reset,
   // register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_reg_write,
   input wire logic       i_reg_read,
   input wire logic [7:0] o_reg_rdata,
   input wire logic [7:0] o_serial_address,
   // pins
   input wire logic       i_addr_select_high,
   input wire logic       i_addr_select_low,
   input wire logic [3:0] i_voltage_id_inputs,
   input wire logic       o_intrusion_pin_out,
   input wire logic       o_intrusion_pin_oe,
   // temperature
   input wire logic [8:0] i_temp_value,
   input wire logic       i_conv_done,
   input wire logic [7:0] i_hot_limit,
   input wire logic       i_status_read,
   input wire logic       o_temp_alert
);
   logic        clr_bit;
   logic        oe_q;
   logic [31:0] hi_cnt;
   logic [1:0]  mode;
   logic        trig;
   logic        above_hot;
   logic        below_hot;
   // trigger only counts while the self clearing bit is low
   assign trig = i_reg_write && i_reg_addr == mcr_pkg::INTR_CLEAR_ADDR && i_reg_wdata[7] && !clr_bit;
   assign above_hot = $signed(i_temp_value[8:1]) > $signed(i_hot_limit);
   assign below_hot = $signed(i_temp_value[8:1]) < $signed(i_hot_limit);
   // shadow of clear bit, pulse length and mode field
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         clr_bit <= 1'h0;
         oe_q    <= 1'h0;
         hi_cnt  <= 32'h0000_0000;
         mode    <= mcr_pkg::TEMP_MODE_RESET;
      end else begin
         oe_q   <= o_intrusion_pin_oe;
         hi_cnt <= o_intrusion_pin_oe ? hi_cnt + 32'h0000_0001 : 32'h0000_0000;
         if (trig) begin
            clr_bit <= 1'h1;
         end else if (oe_q && !o_intrusion_pin_oe) begin
            clr_bit <= 1'h0;
         end
         if (i_reg_write && i_reg_addr == mcr_pkg::TEMP_CONFIG_ADDR) begin
            mode <= i_reg_wdata[1:0];
         end
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // ************************************************************************
   // properties
   // ************************************************************************
   sequence s_launch;
      !o_intrusion_pin_oe ##1 o_intrusion_pin_oe;
   endsequence
   pulse_start_a: assert property (trig |=> s_launch)
      else $error("intrusion pulse did not start two cycles after the write");
   pulse_cause_a: assert property ($rose(o_intrusion_pin_oe) |-> $past(trig, 2))
      else $error("intrusion pulse without a trigger");
   pulse_width_a: assert property ($fell(o_intrusion_pin_oe) |-> hi_cnt == 32'(CLEAR_PULSE_CYCLES))
      else $error("intrusion pulse length wrong");
   pin_low_a: assert property (o_intrusion_pin_oe |-> !o_intrusion_pin_out)
      else $error("intrusion pin driven high");
   addr_reset_a: assert property ($fell(i_reset) |->
      o_serial_address == {mcr_pkg::BUS_ADDR_PATTERN, i_addr_select_high, i_addr_select_low})
      else $error("bus address reset value wrong");
   addr_write_a: assert property (i_reg_write && i_reg_addr == mcr_pkg::BUS_ADDRESS_ADDR
      |=> o_serial_address == $past(i_reg_wdata))
      else $error("bus address not written");
   vid_read_a: assert property (i_reg_read && i_reg_addr == mcr_pkg::VID_FAN_DIV_ADDR
      |=> o_reg_rdata[3:0] == $past(i_voltage_id_inputs))
      else $error("voltage id readback wrong");
   ninth_read_a: assert property (i_reg_read && i_reg_addr == mcr_pkg::TEMP_CONFIG_ADDR
      |=> o_reg_rdata[7] == $past(i_temp_value[0]))
      else $error("ninth temperature bit readback wrong");
   status_clear_a: assert property (i_status_read && !i_conv_done |=> !o_temp_alert)
      else $error("status read left the alert set");
   hot_set_a: assert property (i_conv_done && above_hot && mode != mcr_pkg::MODE_ONE_TIME
      |=> o_temp_alert)
      else $error("alert not set above hot limit");
   comp_drop_a: assert property (mode == mcr_pkg::MODE_COMPARATOR && i_conv_done && below_hot
      |=> !o_temp_alert)
      else $error("comparator alert kept below hot limit");
endmodule

bind mcr_monitor_config_registers mcr_monitor_config_registers_sva #(
   .CLEAR_PULSE_CYCLES(CLEAR_PULSE_CYCLES)
) u_sva (
   .i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
   .o_serial_address(o_serial_address), .i_addr_select_high(i_addr_select_high),
   .i_addr_select_low(i_addr_select_low), .i_voltage_id_inputs(i_voltage_id_inputs),
   .o_intrusion_pin_out(o_intrusion_pin_out), .o_intrusion_pin_oe(o_intrusion_pin_oe),
   .i_temp_value(i_temp_value), .i_conv_done(i_conv_done), .i_hot_limit(i_hot_limit),
   .i_status_read(i_status_read), .o_temp_alert(o_temp_alert)
);

// >>> dv/mcr_monitor_config_registers_tb.sv
// self-checking testbench of the monitor configuration registers
`timescale 1ns/1ps
module mcr_monitor_config_registers_tb;
   logic       i_clk, i_reset, reg_write, reg_read, voltage_id_fifth_input, pin_out, pin_oe;
   logic       tach1, tach2, conv, status, alert, sel_hi, sel_lo;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, serial_address, fan1, fan2, hot, hyst, rv;
   logic [3:0] voltage_id_fan_divisor;
   logic [8:0] temp;
   int         errors, cmp_count, hi_cycles;

   mcr_monitor_config_registers #(.CLEAR_PULSE_CYCLES(20)) dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_write(reg_write), .i_reg_read(reg_read), .o_reg_rdata(reg_rdata),
      .o_serial_address(serial_address), .i_addr_select_high(sel_hi), .i_addr_select_low(sel_lo),
      .i_voltage_id_inputs(voltage_id_fan_divisor), .i_voltage_id_fifth_input(voltage_id_fifth_input), .o_intrusion_pin_out(pin_out),
      .o_intrusion_pin_oe(pin_oe), .i_fan1_tach(tach1), .i_fan2_tach(tach2), .o_fan1_count(fan1),
      .o_fan2_count(fan2), .i_temp_value(temp), .i_conv_done(conv), .i_hot_limit(hot),
      .i_hyst_limit(hyst), .i_status_read(status), .o_temp_alert(alert));
   mcr_host_model host (.i_clk(i_clk), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
      .o_reg_write(reg_write), .o_reg_read(reg_read), .i_reg_rdata(reg_rdata));

   // 125 MHz clock
   initial begin
      i_clk = 1'h0;
      forever #4 i_clk = ~i_clk;
   end
   // tachometers with periods of 16 and 24 cycles
   initial forever begin
      repeat (8) @(posedge i_clk);
      tach1 <= ~tach1;
   end
   initial forever begin
      repeat (12) @(posedge i_clk);
      tach2 <= ~tach2;
   end
   // length of the intrusion pulse
   always @(posedge i_clk) if (pin_oe === 1'h1) hi_cycles <= hi_cycles + 1;
   // ************************************************************************
   // helpers
   // ************************************************************************
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, rv);
      check(rv, exp, "register readback");
   endtask
   task automatic rng(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
      check({7'h00, v >= lo && v <= hi}, 8'h01, "fan count out of range");
   endtask
   task automatic stop_test;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wait_oe(input logic lvl);
      int n;
      n = 0;
      while (pin_oe !== lvl && n < 50) begin
         @(negedge i_clk);
         n++;
      end
      if (n == 50) begin
         errors++;
         $display("ERROR %0t: intrusion pin wait expired", $time);
         stop_test();
      end
   endtask
   // one conversion (kind 1) or status read (kind 0), then the alert level
   task automatic step(input logic kind, input logic [7:0] t, input logic exp);
      @(posedge i_clk);
      temp   <= {t, 1'h0};
      conv   <= kind;
      status <= !kind;
      @(posedge i_clk);
      conv   <= 1'h0;
      status <= 1'h0;
      @(negedge i_clk);
      check({7'h00, alert}, {7'h00, exp}, "temperature alert");
   endtask
   // ************************************************************************
   // scenarios
   // ************************************************************************
   task automatic test_reset;
      check(serial_address, 8'h2e, "bus address after reset");
      rdchk(8'h46, 8'h00);
      rdchk(8'h47, 8'h09);
      rdchk(8'h49, 8'h81);
      rdchk(8'h4b, 8'h01);
      rdchk(8'h45, 8'h00);
   endtask
   task automatic test_temp;
      step(1, 8'h23, 0); step(1, 8'h32, 1); step(0, 8'h32, 0);
      step(1, 8'h32, 0); step(1, 8'h23, 0); step(1, 8'h14, 1);
      step(0, 8'h14, 0); step(1, 8'h14, 0); step(1, 8'h32, 1); step(0, 8'h32, 0);
      for (int m = 0; m < 2; m++) begin
         host.wr(8'h4b, m ? 8'h03 : 8'h00);
         step(1, 8'h14, 0); step(1, 8'h32, 1); step(0, 8'h32, 0);
         step(1, 8'h23, 1); step(0, 8'h23, 0); step(1, 8'h14, 0); step(1, 8'h23, 0);
      end
      host.wr(8'h4b, 8'h02);
      step(1, 8'h32, 1); step(1, 8'h23, 0); step(1, 8'h32, 1); step(0, 8'h32, 0);
      step(1, 8'h32, 1); step(1, 8'h28, 1); step(1, 8'h14, 0);
   endtask
   task automatic test_fields;
      @(posedge i_clk) voltage_id_fan_divisor <= 4'h6;
      host.wr(8'h47, 8'haf);
      rdchk(8'h47, 8'ha6);
      host.wr(8'h49, 8'h00);
      rdchk(8'h49, 8'h01);
      host.wr(8'h48, 8'h5a);
      rdchk(8'h48, 8'h5a);
      check(serial_address, 8'h5a, "bus address");
      host.wr(8'h4b, 8'hfc);
      rdchk(8'h4b, 8'h7c);
      @(posedge i_clk) temp <= 9'h015;
      rdchk(8'h4b, 8'hfc);
      host.wr(8'h45, 8'hff);
      rdchk(8'h45, 8'h00);
   endtask
   task automatic test_fans;
      host.wr(8'h47, 8'h00);
      repeat (60) @(negedge i_clk);
      rng(fan1, 8'h0d, 8'h11);
      rng(fan2, 8'h15, 8'h19);
      host.wr(8'h47, 8'hb0);
      repeat (80) @(negedge i_clk);
      rng(fan1, 8'h01, 8'h03);
      rng(fan2, 8'h05, 8'h07);
   endtask
   task automatic test_intrusion;
      hi_cycles = 0;
      host.wr(8'h46, 8'h85);
      rdchk(8'h46, 8'h85);
      host.wr(8'h46, 8'h80);
      wait_oe(1'h1);
      wait_oe(1'h0);
      check(8'(hi_cycles), 8'h14, "intrusion pulse length");
      check({7'h00, pin_out}, 8'h00, "intrusion drive level");
      repeat (2) @(posedge i_clk);
      rdchk(8'h46, 8'h00);
   endtask
   // reset again mid-run with the straps swapped, written fields must return
   task automatic test_reset_again;
      @(posedge i_clk);
      i_reset <= 1'h1;
      sel_hi  <= 1'h0;
      sel_lo  <= 1'h1;
      repeat (3) @(posedge i_clk);
      i_reset <= 1'h0;
      @(negedge i_clk);
      check(serial_address, 8'h2d, "bus address after second reset");
      rdchk(8'h49, 8'h81);
      rdchk(8'h4b, 8'h81);
   endtask

   // reset, then the scenarios in turn
   initial begin
      i_reset = 1'h1;
      voltage_id_fan_divisor = 4'h9;
      voltage_id_fifth_input = 1'h1;
      sel_hi = 1'h1;
      sel_lo = 1'h0;
      tach1 = 1'h0;
      tach2 = 1'h0;
      temp = 9'h000;
      conv = 1'h0;
      status = 1'h0;
      hot = 8'h28;
      hyst = 8'h1e;
      errors = 0;
      cmp_count = 0;
      hi_cycles = 0;
      repeat (3) @(posedge i_clk);
      i_reset <= 1'h0;
      @(negedge i_clk);
      test_reset();
      test_temp();
      test_fields();
      test_fans();
      test_intrusion();
      test_reset_again();
      stop_test();
   end
endmodule

// >>> rtl/mcr_fan_counter.sv
// fan tachometer period counter with a divisor on the count clock
`timescale 1ns/1ps
module mcr_fan_counter (
   // clock and reset
   input  wire logic                         i_clk,
   input  wire logic                         i_reset,
   // tachometer and divisor
   input  wire logic                         i_tach,
   input  wire logic [1:0]                   i_divisor,
   // reading
   output logic [mcr_pkg::FAN_CNT_W-1:0]     o_count
);

   typedef struct packed {
      logic [7:0]                     presc;
      logic [mcr_pkg::FAN_CNT_W-1:0]  cnt;
      logic                           tach_prev;
      logic [mcr_pkg::FAN_CNT_W-1:0]  reading;
   } mcr_fan_state_type;

   mcr_fan_state_type state;
   mcr_fan_state_type next_state;
   logic [7:0]        presc_last;

   // divide by 1, 2, 4 or 8 on the count clock
   assign presc_last = 8'(({7'h00, 1'b1} << i_divisor) - 8'h01);

   // count scaled ticks between rising tach edges, saturate on stalled fan
   always_comb begin
      next_state           = state;
      next_state.tach_prev = i_tach;
      if (i_tach && !state.tach_prev) begin
         next_state.reading = state.cnt;
         next_state.cnt     = '0;
         next_state.presc   = '0;
      end else if (state.presc >= presc_last) begin
         next_state.presc = '0;
         if (state.cnt != mcr_pkg::FAN_CNT_MAX) begin
            next_state.cnt = state.cnt + 1'b1;
         end
      end else begin
         next_state.presc = state.presc + 8'h01;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign o_count = state.reading;

endmodule

// >>> rtl/mcr_monitor_config_registers.sv
// configuration and status registers of the system monitor
`timescale 1ns/1ps
module mcr_monitor_config_registers #(
   parameter int CLEAR_PULSE_CYCLES = mcr_pkg::CLEAR_PULSE_CYCLES
) (
   // clock and reset
   input  wire logic                          i_clk,
   input  wire logic                          i_reset,
   // register port from the serial engine
   input  wire logic [7:0]                    i_reg_addr,
   input  wire logic [7:0]                    i_reg_wdata,
   input  wire logic                          i_reg_write,
   input  wire logic                          i_reg_read,
   output logic      [7:0]                    o_reg_rdata,
   output logic      [7:0]                    o_serial_address,
   // address select straps
   input  wire logic                          i_addr_select_high,
   input  wire logic                          i_addr_select_low,
   // voltage id pins
   input  wire logic [3:0]                    i_voltage_id_inputs,
   input  wire logic                          i_voltage_id_fifth_input,
   // intrusion pin, open drain
   output logic                               o_intrusion_pin_out,
   output logic                               o_intrusion_pin_oe,
   // fan tachometers and readings
   input  wire logic                          i_fan1_tach,
   input  wire logic                          i_fan2_tach,
   output logic      [mcr_pkg::FAN_CNT_W-1:0] o_fan1_count,
   output logic      [mcr_pkg::FAN_CNT_W-1:0] o_fan2_count,
   // temperature path
   input  wire logic [8:0]                    i_temp_value,
   input  wire logic                          i_conv_done,
   input  wire logic [7:0]                    i_hot_limit,
   input  wire logic [7:0]                    i_hyst_limit,
   input  wire logic                          i_status_read,
   output logic                               o_temp_alert
);

   // ************************************************************************
   // state
   // ************************************************************************
   typedef struct packed {
      logic                   intr_clear;
      logic [6:0]             intr_rsv;
      logic [3:0]             fan_div;
      logic [7:0]             bus_addr;
      logic [6:0]             vid_high_rsv;
      logic [1:0]             temp_mode;
      logic [4:0]             temp_rsv;
      logic [7:0]             rdata;
      logic                   temp_error;
      logic                   hot_active;
      mcr_pkg::mcr_otime_type otime;
      logic                   clear_start;
      logic                   pin_out;
   } mcr_state_type;

   mcr_state_type state;
   mcr_state_type next_state;

   logic pulse_active;
   logic pulse_done;
   logic wr_intr;
   logic wr_vid;
   logic wr_bus;
   logic wr_vidh;
   logic wr_temp;
   logic above_hot;
   logic below_hyst;
   logic below_hot;
   logic set_flag;
   logic clr_flag;

   // ************************************************************************
   // write decode
   // ************************************************************************
   assign wr_intr = i_reg_write && (i_reg_addr == mcr_pkg::INTR_CLEAR_ADDR);
   assign wr_vid  = i_reg_write && (i_reg_addr == mcr_pkg::VID_FAN_DIV_ADDR);
   assign wr_bus  = i_reg_write && (i_reg_addr == mcr_pkg::BUS_ADDRESS_ADDR);
   assign wr_vidh = i_reg_write && (i_reg_addr == mcr_pkg::VID_HIGH_ADDR);
   assign wr_temp = i_reg_write && (i_reg_addr == mcr_pkg::TEMP_CONFIG_ADDR);

   // ************************************************************************
   // temperature compares, signed on the upper eight result bits
   // ************************************************************************
   assign above_hot  = $signed(i_temp_value[8:1]) > $signed(i_hot_limit);
   assign below_hot  = $signed(i_temp_value[8:1]) < $signed(i_hot_limit);
   assign below_hyst = $signed(i_temp_value[8:1]) < $signed(i_hyst_limit);

   // set and clear terms of the temperature flag per mode
   always_comb begin
      set_flag = 1'b0;
      clr_flag = i_status_read;
      case (state.temp_mode)
         mcr_pkg::MODE_ONE_TIME: begin
            if (i_conv_done) begin
               if (state.otime == mcr_pkg::OT_WAIT_HIGH) begin
                  set_flag = above_hot;
               end else begin
                  set_flag = below_hyst;
               end
            end
         end
         mcr_pkg::MODE_COMPARATOR: begin
            set_flag = i_conv_done && above_hot;
            clr_flag = i_status_read || (i_conv_done && below_hot);
         end
         default: begin
            // modes 00 and 11 share the default behaviour
            set_flag = i_conv_done && (above_hot || (state.hot_active && !below_hyst));
         end
      endcase
   end

   // ************************************************************************
   // next state
   // ************************************************************************
   always_comb begin
      next_state             = state;
      next_state.clear_start = 1'b0;
      next_state.pin_out     = 1'b0;

      // intrusion clear: bit 7 holds until the pulse has been output
      if (wr_intr) begin
         next_state.intr_rsv = i_reg_wdata[6:0];
         if (i_reg_wdata[mcr_pkg::INTR_CLEAR_BIT] && !state.intr_clear) begin
            next_state.intr_clear  = 1'b1;
            next_state.clear_start = 1'b1;
         end
      end
      if (pulse_done) begin
         next_state.intr_clear = 1'b0;
      end

      // divisors, bus address, temperature mode and reserved fields
      if (wr_vid) begin
         next_state.fan_div = i_reg_wdata[7:4];
      end
      if (wr_bus) begin
         next_state.bus_addr = i_reg_wdata;
      end
      if (wr_vidh) begin
         next_state.vid_high_rsv = i_reg_wdata[7:1];
      end
      if (wr_temp) begin
         next_state.temp_mode = i_reg_wdata[1:0];
         next_state.temp_rsv  = i_reg_wdata[6:2];
      end

      // hysteresis tracking for default mode
      if (i_conv_done) begin
         if (above_hot) begin
            next_state.hot_active = 1'b1;
         end else if (below_hyst) begin
            next_state.hot_active = 1'b0;
         end
      end

      // one-time mode armed direction flips on each flagged crossing
      if ((state.temp_mode == mcr_pkg::MODE_ONE_TIME) && set_flag) begin
         if (state.otime == mcr_pkg::OT_WAIT_HIGH) begin
            next_state.otime = mcr_pkg::OT_WAIT_LOW;
         end else begin
            next_state.otime = mcr_pkg::OT_WAIT_HIGH;
         end
      end

      // set wins over a clear in the same cycle
      if (set_flag) begin
         next_state.temp_error = 1'b1;
      end else if (clr_flag) begin
         next_state.temp_error = 1'b0;
      end

      // read data, pins sampled at the read
      next_state.rdata = 8'h00;
      if (i_reg_read) begin
         case (i_reg_addr)
            mcr_pkg::INTR_CLEAR_ADDR: begin
               next_state.rdata = {state.intr_clear, state.intr_rsv};
            end
            mcr_pkg::VID_FAN_DIV_ADDR: begin
               next_state.rdata = {state.fan_div, i_voltage_id_inputs};
            end
            mcr_pkg::BUS_ADDRESS_ADDR: begin
               next_state.rdata = state.bus_addr;
            end
            mcr_pkg::VID_HIGH_ADDR: begin
               next_state.rdata = {state.vid_high_rsv, i_voltage_id_fifth_input};
            end
            mcr_pkg::TEMP_CONFIG_ADDR: begin
               next_state.rdata = {i_temp_value[0], state.temp_rsv, state.temp_mode};
            end
            default: begin
               next_state.rdata = 8'h00;
            end
         endcase
      end
   end

   // ************************************************************************
   // registers; reset loads the address straps
   // ************************************************************************
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state              <= '0;
         state.intr_clear   <= mcr_pkg::INTR_CLEAR_RESET[mcr_pkg::INTR_CLEAR_BIT];
         state.intr_rsv     <= mcr_pkg::INTR_CLEAR_RESET[6:0];
         state.fan_div      <= mcr_pkg::FAN_DIV_RESET;
         state.bus_addr     <= {mcr_pkg::BUS_ADDR_PATTERN, i_addr_select_high, i_addr_select_low};
         state.vid_high_rsv <= mcr_pkg::VID_HIGH_RESET;
         state.temp_mode    <= mcr_pkg::TEMP_MODE_RESET;
         state.temp_rsv     <= mcr_pkg::TEMP_RSV_RESET;
         state.otime        <= mcr_pkg::OT_WAIT_HIGH;
      end else begin
         state <= next_state;
      end
   end

   // ************************************************************************
   // intrusion pulse and fan counters
   // ************************************************************************
   mcr_pulse_timer #(
      .PULSE_CYCLES (CLEAR_PULSE_CYCLES)
   ) u_pulse (
      .i_clk    (i_clk),
      .i_reset  (i_reset),
      .i_start  (state.clear_start),
      .o_active (pulse_active),
      .o_done   (pulse_done)
   );

   // one counter per fan, each with its own divisor field
   mcr_fan_counter u_fan1 (
      .i_clk     (i_clk),
      .i_reset   (i_reset),
      .i_tach    (i_fan1_tach),
      .i_divisor (state.fan_div[1:0]),
      .o_count   (o_fan1_count)
   );

   mcr_fan_counter u_fan2 (
      .i_clk     (i_clk),
      .i_reset   (i_reset),
      .i_tach    (i_fan2_tach),
      .i_divisor (state.fan_div[3:2]),
      .o_count   (o_fan2_count)
   );

   // ************************************************************************
   // outputs
   // ************************************************************************
   assign o_reg_rdata         = state.rdata;
   assign o_serial_address    = state.bus_addr;
   assign o_intrusion_pin_out = state.pin_out; // open drain, only ever pulls low
   assign o_intrusion_pin_oe  = pulse_active;
   assign o_temp_alert        = state.temp_error;

endmodule

// >>> rtl/mcr_pulse_timer.sv
// one-shot low pulse timer for the intrusion clear
`timescale 1ns/1ps
module mcr_pulse_timer #(
   parameter int PULSE_CYCLES = mcr_pkg::CLEAR_PULSE_CYCLES
) (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset,
   // control
   input  wire logic i_start,
   output logic      o_active,
   output logic      o_done
);

   localparam logic [mcr_pkg::PULSE_CNT_W-1:0] LAST = mcr_pkg::PULSE_CNT_W'(PULSE_CYCLES - 1);

   typedef struct packed {
      logic                           active;
      logic                           done;
      logic [mcr_pkg::PULSE_CNT_W-1:0] cnt;
   } mcr_pulse_state_type;

   mcr_pulse_state_type state;
   mcr_pulse_state_type next_state;

   // full count of cycles before release, so the pulse never runs short
   always_comb begin
      next_state      = state;
      next_state.done = 1'b0;
      if (state.active) begin
         if (state.cnt == LAST) begin
            next_state.active = 1'b0;
            next_state.done   = 1'b1;
            next_state.cnt    = '0;
         end else begin
            next_state.cnt = state.cnt + 1'b1;
         end
      end else if (i_start) begin
         next_state.active = 1'b1;
         next_state.cnt    = '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign o_active = state.active;
   assign o_done   = state.done;

endmodule
